// >>> logic/cfle_bank.v
// Critical fault log enable registers, trigger and lock logic
`include "cfle_defines.vh"
module cfle_bank #(
	parameter N_INPUTS = 12
) (
	input  wire                clk,
	input  wire                arst_n,
	input  wire [7:0]          addr,
	input  wire [7:0]          wdata,
	input  wire                wr,
	input  wire                rd,
	output reg  [7:0]          rdata,
	input  wire [N_INPUTS-1:0] uv_fault,
	input  wire [N_INPUTS-1:0] ov_fault,
	output reg                 seq_off,
	output reg                 log_start,
	output reg                 log_flags,
	output reg                 log_values,
	output reg                 log_locked,
	output reg  [N_INPUTS-1:0] fault_flag,
	output reg                 irq
);
	// ==========================================================
	// Registers
	reg [1:0]          ctrl;
	reg [7:0]          uv_low;
	reg [7:0]          uv_ov;
	reg [7:0]          ov_mid;
	reg [1:0]          status;
	reg [1:0]          mask;
	reg [N_INPUTS-1:0] uv_s1;
	reg [N_INPUTS-1:0] uv_s2;
	reg [N_INPUTS-1:0] ov_s1;
	reg [N_INPUTS-1:0] ov_s2;
	reg [N_INPUTS-1:0] uv_en;
	reg [N_INPUTS-1:0] ov_en;
	reg [N_INPUTS-1:0] hit;
	reg [N_INPUTS-1:0] flag_clr;
	reg [15:0]         flag_pad;
	wire               any_hit;
	wire               do_log;
	wire               unlock_wr;
	wire [1:0]         st_set;
	wire [1:0]         st_clr;

	// Write decode shared by all write-one actions
	function hitw;
		input [7:0] a;
		input [7:0] off;
		begin
			hitw = (a == off);
		end
	endfunction

	// ==========================================================
	// Enable mapping of register bits to inputs
	always @* begin
		uv_en = {N_INPUTS{1'b0}};
		ov_en = {N_INPUTS{1'b0}};
		uv_en[7:0] = uv_low;
		uv_en[11:8] = uv_ov[3:0];
		ov_en[2:0] = uv_ov[6:4];
		ov_en[3] = uv_ov[7];
		ov_en[7:4] = ov_mid[3:0];
		ov_en[9:8] = ov_mid[5:4];
		hit = (uv_s2 & uv_en) | (ov_s2 & ov_en);
		flag_clr = {N_INPUTS{1'b0}};
		flag_pad = 16'h0000;
		if (wr && hitw(addr, `CFLE_OFF_FLAG_LO))
			flag_pad[7:0] = wdata;
		if (wr && hitw(addr, `CFLE_OFF_FLAG_HI))
			flag_pad[15:8] = wdata;
		flag_clr = flag_pad[N_INPUTS-1:0];
	end

	assign any_hit   = |hit;
	// Only one log per unlock; later faults are blocked
	assign do_log    = any_hit & ~log_locked;
	assign unlock_wr = wr & hitw(addr, `CFLE_OFF_UNLOCK)
		& wdata[`CFLE_UNLOCK_BIT];
	assign st_set    = {any_hit & log_locked, do_log};
	assign st_clr    = (wr && hitw(addr, `CFLE_OFF_STATUS)) ?
		wdata[1:0] : 2'h0;

	// ==========================================================
	// Fault input synchronisers; fault sources are off-domain
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			uv_s1 <= {N_INPUTS{1'b0}};
			uv_s2 <= {N_INPUTS{1'b0}};
			ov_s1 <= {N_INPUTS{1'b0}};
			ov_s2 <= {N_INPUTS{1'b0}};
		end else begin
			uv_s1 <= uv_fault;
			uv_s2 <= uv_s1;
			ov_s1 <= ov_fault;
			ov_s2 <= ov_s1;
		end
	end

	// ==========================================================
	// Register writes
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl   <= `CFLE_MODE_BOTH;
			uv_low <= `CFLE_RST_BYTE;
			uv_ov  <= `CFLE_RST_BYTE;
			ov_mid <= `CFLE_RST_BYTE;
			mask   <= 2'h0;
		end else if (wr) begin
			if (hitw(addr, `CFLE_OFF_CTRL))
				ctrl <= wdata[1:0];
			if (hitw(addr, `CFLE_OFF_UV_LOW))
				uv_low <= wdata;
			if (hitw(addr, `CFLE_OFF_UV_OV))
				uv_ov <= wdata;
			if (hitw(addr, `CFLE_OFF_OV_MID))
				ov_mid <= wdata;
			if (hitw(addr, `CFLE_OFF_MASK))
				mask <= wdata[1:0];
		end
	end

	// ==========================================================
	// Flags, lock, log request; set wins over clear
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fault_flag <= {N_INPUTS{1'b0}};
			log_locked <= 1'b0;
			seq_off    <= 1'b0;
			log_start  <= 1'b0;
			log_flags  <= 1'b0;
			log_values <= 1'b0;
			status     <= 2'h0;
			irq        <= 1'b0;
		end else begin
			fault_flag <= (fault_flag & ~flag_clr) | hit;
			status     <= (status & ~st_clr) | st_set;
			irq        <= |(((status & ~st_clr) | st_set) & mask);
			log_start  <= do_log;
			// Mode 11 still shuts down, but stores nothing
			log_flags  <= do_log & ((ctrl == `CFLE_MODE_BOTH) |
				(ctrl == `CFLE_MODE_FLAGS));
			log_values <= do_log & ((ctrl == `CFLE_MODE_BOTH) |
				(ctrl == `CFLE_MODE_VALUES));
			if (any_hit)
				seq_off <= 1'b1;
			else if (unlock_wr)
				seq_off <= 1'b0;
			if (do_log)
				log_locked <= 1'b1;
			else if (unlock_wr)
				log_locked <= 1'b0;
		end
	end

	// ==========================================================
	// Read port; data one cycle after the strobe, zero otherwise
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			rdata <= 8'h00;
		else if (!rd)
			rdata <= 8'h00;
		else begin
			case (addr)
			`CFLE_OFF_CTRL:    rdata <= {6'h00, ctrl};
			`CFLE_OFF_UV_LOW:  rdata <= uv_low;
			`CFLE_OFF_UV_OV:   rdata <= uv_ov;
			`CFLE_OFF_OV_MID:  rdata <= ov_mid;
			`CFLE_OFF_STATUS:  rdata <= {6'h00, status};
			`CFLE_OFF_MASK:    rdata <= {6'h00, mask};
			`CFLE_OFF_UNLOCK:  rdata <= {6'h00, log_locked, 1'b0};
			`CFLE_OFF_FLAG_LO: rdata <= fault_flag[7:0];
			`CFLE_OFF_FLAG_HI: rdata <= {4'h0, fault_flag[11:8]};
			default:           rdata <= 8'h00;
			endcase
		end
	end
endmodule // cfle_bank

// >>> pkg/cfle_defines.vh
// Constants for the critical fault log enable register bank
// Behaviour
// - Log control 00 saves flags and values, 01 flags, 10 values, 11 nothing.
// - First undervoltage enable bit n routes undervoltage of input n+1 to logging.
// - Second enable bits 0-3 route undervoltage of inputs 9-12 to logging.
// - Second enable bits 4-6 route overvoltage of inputs 1-3 to logging.
// - Third enable bits 0-3 route overvoltage of inputs 5-8 to logging.
// - Third enable bits 4-5 route overvoltage of inputs 9-10 to logging.
// - Enabled critical fault turns off sequencing outputs and starts a log transfer.
// - After a log the memory locks; software writes unlock before next log.
// - Per-input flag sets only when its enable is set; fault outputs unmasked.
`ifndef CFLE_DEFINES_VH
`define CFLE_DEFINES_VH
// ==========================================================
// Register offsets
`define CFLE_OFF_CTRL    8'h47
`define CFLE_OFF_UV_LOW  8'h48
`define CFLE_OFF_UV_OV   8'h49
`define CFLE_OFF_OV_MID  8'h4A
`define CFLE_OFF_STATUS  8'h50
`define CFLE_OFF_MASK    8'h51
`define CFLE_OFF_UNLOCK  8'h52
`define CFLE_OFF_FLAG_LO 8'h53
`define CFLE_OFF_FLAG_HI 8'h54
// ==========================================================
// Fields
`define CFLE_MODE_BOTH   2'h0
`define CFLE_MODE_FLAGS  2'h1
`define CFLE_MODE_VALUES 2'h2
`define CFLE_MODE_NONE   2'h3
`define CFLE_UNLOCK_BIT  1
`define CFLE_ST_LOG      0
`define CFLE_ST_BLOCKED  1
`define CFLE_RST_BYTE    8'h00
`endif

// >>> verification/cfle_props.sv
// Port checks of the fault log enable bank
module cfle_props #(
	parameter N_INPUTS = 12
) (
	input wire logic                clk,
	input wire logic                arst_n,
	input wire logic                wr,
	input wire logic [N_INPUTS-1:0] uv_fault,
	input wire logic [N_INPUTS-1:0] ov_fault,
	input wire logic                seq_off,
	input wire logic                log_start,
	input wire logic                log_flags,
	input wire logic                log_values,
	input wire logic                log_locked,
	input wire logic [N_INPUTS-1:0] fault_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// Pin levels; two sync flops plus one register make three edges
	wire [N_INPUTS-1:0] pin_vec = uv_fault | ov_fault;
	wire                pin_any = |pin_vec;
	sequence s_hit;
		$past(pin_any, 3);
	endsequence
	property p_flags; log_flags |-> log_start; endproperty
	a_flags: assert property (p_flags) else $error("flags alone");
	property p_vals; log_values |-> log_start; endproperty
	a_vals: assert property (p_vals) else $error("values alone");
	property p_cause; log_start |-> s_hit; endproperty
	a_cause: assert property (p_cause) else $error("no cause");
	property p_lock; log_start |-> $rose(log_locked); endproperty
	a_lock: assert property (p_lock) else $error("log while locked");
	property p_off; log_start |-> seq_off; endproperty
	a_off: assert property (p_off) else $error("outputs on");
	property p_offh; seq_off && !wr |=> seq_off; endproperty
	a_offh: assert property (p_offh) else $error("off lost");
	property p_lockh; log_locked && !wr |=> log_locked; endproperty
	a_lockh: assert property (p_lockh) else $error("lock lost");
	// A new flag needs its own pin active three edges before
	property p_flag;
		(fault_flag & ~$past(fault_flag) & ~$past(pin_vec, 3)) == 0;
	endproperty
	a_flag: assert property (p_flag) else $error("flag no fault");
endmodule // cfle_props
bind cfle_bank cfle_props #(.N_INPUTS(N_INPUTS)) cfle_props_inst (.*);

// >>> verification/tb.sv
// Register-level bench of the fault log enable bank
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0, arst_n = 0, wr = 0, rd = 0, o;
	logic [7:0]  addr = 0, wdata = 0, rdata, a;
	logic [11:0] uv_fault = 0, ov_fault = 0, fault_flag;
	logic        seq_off, log_start, log_flags, log_values, log_locked, irq;
	logic [1:0]  lf;
	int          num_errors = 0, num_checks = 0, starts = 0, n = 0, b, i;
	cfle_bank cfle_bank_inst (.*);
	always #2.5 clk = ~clk;
	// Count log starts and keep what each asked to store
	always @(posedge clk) if (log_start) begin
		starts <= starts + 1;
		lf <= {log_flags, log_values};
	end
	task automatic chk(input logic [15:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [7:0] ad, d);
		@(posedge clk);
		{addr, wdata, wr} <= {ad, d, 1'b1};
		@(posedge clk);
		wr <= 0;
	endtask
	task automatic rreg(input logic [7:0] ad, input logic [15:0] exp);
		@(posedge clk);
		{addr, rd} <= {ad, 1'b1};
		@(posedge clk);
		rd <= 0;
		@(negedge clk);
		chk({8'h00, rdata}, exp);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		arst_n <= 1;
		// Mapped places read 0 after reset, unmapped ones always
		wreg(8'h60, 8'hFF);
		for (int r = 'h47; r <= 'h60; r++) rreg(8'(r), 0);
		// Faults with every enable clear must not log or flag
		@(posedge clk);
		{uv_fault, ov_fault} <= '1;
		repeat (6) @(posedge clk);
		chk({seq_off, log_locked, fault_flag}, 0);
		{uv_fault, ov_fault} <= 0;
		$display("test reset done");
		// One enable at a time with all inputs faulty in that enable's direction only; mode and mask vary
		for (int k = 0; k < 24; k++) begin
			o = k >= 12;
			i = k % 12;
			if (o && i > 9) continue;
			a = !o ? (i < 8 ? 8'h48 : 8'h49) : (i < 4 ? 8'h49 : 8'h4A);
			b = !o ? i % 8 : (i < 3 ? i + 4 : (i == 3 ? 7 : i - 4));
			wreg(8'h47, 8'(k % 4));
			wreg(8'h51, 8'(k % 2));
			wreg(a, 8'(1 << b));
			rreg(a, 16'(1 << b));
			@(posedge clk);
			if (o) ov_fault <= '1; else uv_fault <= '1;
			repeat (6) @(posedge clk);
			n++;
			chk(fault_flag, 16'(1 << i));
			chk({seq_off, log_locked, irq, lf}, {2'h3, 1'(k), ~2'(k)});
			// A fresh fault while locked must not log again
			{uv_fault, ov_fault} <= 0;
			repeat (4) @(posedge clk);
			if (o) ov_fault <= '1; else uv_fault <= '1;
			repeat (6) @(posedge clk);
			chk(16'(starts), 16'(n));
			rreg(8'h52, 16'h0002);
			@(posedge clk);
			{uv_fault, ov_fault} <= 0;
			wreg(a, 8'h00);
			wreg(8'h52, 8'h02);
			wreg(8'h53, 8'hFF);
			wreg(8'h54, 8'h0F);
			wreg(8'h50, 8'h03);
			@(negedge clk);
			chk({seq_off, log_locked, irq, fault_flag}, 0);
		end
		$display("test map done");
		tally_and_finish;
	end
endmodule // tb
